// file: core/radio_spi_slave_port.sv
// radio serial slave port: register core, sleep control, battery, signal_strength_reading
// assumes an Avalon-MM master on clk and an external serial master on pins
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module radio_spi_slave_port #(
   parameter int OSC_NS  = `OSC_RESTART_NS,
   parameter int SIGNAL_STRENGTH_READING_NS = `SIGNAL_STRENGTH_READING_GAP_NS
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   input  wire logic        sck,
   input  wire logic        ss_n,
   input  wire logic        mosi_in,
   output var  logic        mosi_out,
   output var  logic        mosi_oe_n,
   output var  logic        miso_out,
   output var  logic        miso_oe_n,
   output var  logic        irq,
   input  wire logic [2:0]  battery_level,
   input  wire logic [4:0]  rf_level,
   input  wire logic        pkt_start,
   input  wire logic        pkt_done,
   output var  logic        asleep,
   output var  logic        osc_run,
   output var  logic        gain_cut_20db,
   output var  logic        gain_cut_40db,
   output var  logic        agc_active
);
   localparam int OSC_RAW  = (OSC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int OSC_CYC  = (OSC_RAW < 1) ? 1 : OSC_RAW;
   localparam int SIGNAL_STRENGTH_READING_RAW = (SIGNAL_STRENGTH_READING_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int SIGNAL_STRENGTH_READING_CYC = (SIGNAL_STRENGTH_READING_RAW < 1) ? 1 : SIGNAL_STRENGTH_READING_RAW;
   localparam logic [`OSC_CNT_W-1:0]  OSC_LOAD  = `OSC_CNT_W'(OSC_CYC - 1);
   localparam logic [`SIGNAL_STRENGTH_READING_CNT_W-1:0] SIGNAL_STRENGTH_READING_LOAD = `SIGNAL_STRENGTH_READING_CNT_W'(SIGNAL_STRENGTH_READING_CYC - 1);

   radio_spi_pkg::port_state_t s_r;
   radio_spi_pkg::port_state_t n;
   spi_shift_if                ifc ();
   logic [12:0]                pins_s;
   logic [2:0]                 bat_s;
   logic [4:0]                 rf_s;
   logic                       pstart_s;
   logic                       pdone_s;
   logic                       lowbat_now;
   logic                       spi_data;
   logic                       irq_any;
   logic                       shared;
   logic                       four;
   logic                       reading;
   logic                       wake_set;
   logic [5:0]                 av_idx;
   logic [5:0]                 nxt_addr;

   pin_sync #(
      .W    (13),
      .INIT (`SYNC_INIT)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .d      ({rf_level, battery_level, pkt_done, pkt_start, mosi_in, ss_n, sck}),
      .q      (pins_s)
   );

   spi_shift_engine u_engine (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .ifc    (ifc.engine)
   );

   assign ifc.sck_s   = pins_s[0];
   assign ifc.ss_n_s  = pins_s[1];
   assign ifc.sdi_s   = pins_s[2];
   assign pstart_s    = pins_s[3];
   assign pdone_s     = pins_s[4];
   assign bat_s       = pins_s[7:5];
   assign rf_s        = pins_s[12:8];
   assign ifc.tx_byte = s_r.tx_byte;
   assign av_idx      = avs_address[`AV_IDX_HI:`AV_IDX_LO];
   assign spi_data    = ifc.rx_valid && !ifc.rx_first && s_r.cmd_valid;

   assign lowbat_now = (s_r.lowbat_cfg[`LOWBAT_THR_HI:0] != 3'h0)
                    && (s_r.pw == radio_spi_pkg::PW_AWAKE)
                    && (bat_s < s_r.lowbat_cfg[`LOWBAT_THR_HI:0]);

   function automatic logic [7:0] rd(input radio_spi_pkg::port_state_t st,
                                     input logic [5:0] a, input logic lb);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         `ADR_CTRL:     r = st.ctrl;
         `ADR_STATUS:
         begin
            r[`ST_ASLEEP] = (st.pw == radio_spi_pkg::PW_SLEEP);
            r[`ST_WAKING] = (st.pw == radio_spi_pkg::PW_WAKING);
            r[`ST_WAKE]   = st.wake_flag;
            r[`ST_LOWBAT] = lb;
         end
         `ADR_RX_CFG:   r = st.rx_cfg;
         `ADR_XACT_CFG: r = st.xact;
         `ADR_SIGNAL_STRENGTH_READING:     r = {3'h0, st.signal_strength_reading};
         `ADR_LOWBAT:   r = {lb, st.lowbat_cfg[6:0]};
         `ADR_BUFFER:   r = st.buf_mem[st.bptr];
         `ADR_SPI_CFG:  r = st.spi_cfg;
         default:       r = 8'h00;
      endcase
      return r;
   endfunction

   // side effects of a read
   function automatic radio_spi_pkg::port_state_t fx(
      input radio_spi_pkg::port_state_t st, input logic [5:0] a);
      radio_spi_pkg::port_state_t r;
      r = st;
      if (a == `ADR_STATUS)
         r.wake_flag = 1'b0;
      if (a == `ADR_SIGNAL_STRENGTH_READING)
         r.signal_strength_reading_pend = 1'b1;
      if (a == `ADR_BUFFER)
         r.bptr = st.bptr + 4'h1;
      return r;
   endfunction

   function automatic radio_spi_pkg::port_state_t wr(
      input radio_spi_pkg::port_state_t st, input logic [5:0] a, input logic [7:0] d);
      radio_spi_pkg::port_state_t r;
      r = st;
      unique case (a)
         `ADR_CTRL:
         begin
            r.ctrl = d & ~`CTRL_GO_MASK;
            // commanded to transmit or receive wakes
            if ((d[`CTRL_TX_GO] || d[`CTRL_RX_GO]) && st.pw == radio_spi_pkg::PW_SLEEP)
            begin
               r.pw = radio_spi_pkg::PW_WAKING;
               r.osc_cnt = OSC_LOAD;
            end
         end
         `ADR_XACT_CFG:
         begin
            r.xact = d;
            r.xact[`XACT_FORCE] = 1'b0;
            if (d[`XACT_FORCE] && d[`XACT_END_HI:`XACT_END_LO] == `END_SLEEP)
               r.pw = radio_spi_pkg::PW_SLEEP;
         end
         `ADR_RX_CFG:  r.rx_cfg = d;
         `ADR_LOWBAT:  r.lowbat_cfg = {1'b0, d[6:0]};
         `ADR_SPI_CFG: r.spi_cfg = d;
         `ADR_BUFFER:
         begin
            r.buf_mem[st.bptr] = d;
            r.bptr = st.bptr + 4'h1;
         end
         default:      r = st;
      endcase
      return r;
   endfunction

   always_comb
   begin
      n = s_r;
      wake_set = 1'b0;
      nxt_addr = s_r.addr;
      shared = s_r.spi_cfg[`SPICFG_IRQ_MOSI];
      four = s_r.spi_cfg[`SPICFG_FOUR];
      reading = s_r.cmd_valid && !s_r.dir && !ifc.ss_n_s;
      irq_any = (s_r.lowbat_cfg[`LOWBAT_IE] && lowbat_now)
             || (s_r.ctrl[`CTRL_WAKE_IE] && s_r.wake_flag);
      n.pstart_d = pstart_s;
      n.pdone_d = pdone_s;

      unique case (s_r.pw)
         radio_spi_pkg::PW_AWAKE:
         begin
            if (pdone_s && !s_r.pdone_d && s_r.ctrl[`CTRL_AUTO_SLEEP])
               n.pw = radio_spi_pkg::PW_SLEEP;
         end
         radio_spi_pkg::PW_SLEEP:
            n.pw = radio_spi_pkg::PW_SLEEP;
         radio_spi_pkg::PW_WAKING:
         begin
            if (s_r.osc_cnt == '0)
            begin
               n.pw = radio_spi_pkg::PW_AWAKE;
               wake_set = 1'b1;
            end
            else
               n.osc_cnt = s_r.osc_cnt - 1'b1;
         end
         default:
            n.pw = radio_spi_pkg::PW_SLEEP;
      endcase

      if (ifc.rx_valid && ifc.rx_first)
      begin
         n.cmd_valid = 1'b1;
         n.dir = ifc.rx_byte[`CMD_DIR];
         n.inc = ifc.rx_byte[`CMD_INC];
         n.addr = ifc.rx_byte[`CMD_ADR_HI:0];
         if (!ifc.rx_byte[`CMD_DIR])
         begin
            n.tx_byte = rd(n, ifc.rx_byte[`CMD_ADR_HI:0], lowbat_now);
            n = fx(n, ifc.rx_byte[`CMD_ADR_HI:0]);
         end
      end
      else if (spi_data)
      begin
         if (s_r.dir)
            n = wr(n, s_r.addr, ifc.rx_byte);
         nxt_addr = s_r.addr + {5'h00, s_r.inc};
         n.addr = nxt_addr;
         // read-ahead: one extra read side effect after the last byte
         if (!s_r.dir)
         begin
            n.tx_byte = rd(n, nxt_addr, lowbat_now);
            n = fx(n, nxt_addr);
         end
      end
      if (ifc.ss_n_s)
         n.cmd_valid = 1'b0;

      // bus access waits a cycle when a serial byte lands
      if (!s_r.av_wait)
      begin
         n.av_wait = 1'b1;
         if (avs_write)
            n = wr(n, av_idx, avs_writedata[7:0]);
      end
      else if ((avs_read || avs_write) && !ifc.rx_valid)
      begin
         n.av_wait = 1'b0;
         n.av_rdata = 8'h00;
         if (avs_read)
         begin
            n.av_rdata = rd(n, av_idx, lowbat_now);
            n = fx(n, av_idx);
         end
      end
      // hardware set beats a clear by read
      n.wake_flag = n.wake_flag | wake_set;

      if (s_r.signal_strength_reading_gap != '0)
         n.signal_strength_reading_gap = s_r.signal_strength_reading_gap - 1'b1;
      if (pstart_s && !s_r.pstart_d && s_r.rx_cfg[`RXCFG_SIGNAL_STRENGTH_READING_EN])
         n.signal_strength_reading_pend = 1'b1;
      if (n.signal_strength_reading_pend && s_r.signal_strength_reading_gap == '0)
      begin
         n.signal_strength_reading = rf_s;
         n.signal_strength_reading_pend = 1'b0;
         n.signal_strength_reading_gap = SIGNAL_STRENGTH_READING_LOAD;
      end

      n.irq = irq_any && !shared;
      n.mosi_oe_n = !((shared && ifc.ss_n_s) || (!four && reading));
      n.mosi_o = (shared && ifc.ss_n_s) ? irq_any : ifc.sdo;
      n.miso_oe_n = !(four && reading);
      n.miso_o = ifc.sdo;
      n.agc_active = s_r.rx_cfg[`RXCFG_AGC];
      n.gain_cut_20db = !s_r.rx_cfg[`RXCFG_AGC] && !s_r.rx_cfg[`RXCFG_LNA];
      n.gain_cut_40db = !s_r.rx_cfg[`RXCFG_AGC] && s_r.rx_cfg[`RXCFG_DAMP];
      n.asleep = (n.pw == radio_spi_pkg::PW_SLEEP);
      n.osc_run = (n.pw != radio_spi_pkg::PW_SLEEP);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_r <= '0;
         s_r.rx_cfg <= `RST_RX_CFG;
         s_r.av_wait <= 1'b1;
         s_r.mosi_oe_n <= 1'b1;
         s_r.miso_oe_n <= 1'b1;
         s_r.osc_run <= 1'b1;
      end
      else if (ce)
         s_r <= n;
   end

   assign avs_readdata    = {24'h000000, s_r.av_rdata};
   assign avs_waitrequest = s_r.av_wait;
   assign mosi_out        = s_r.mosi_o;
   assign mosi_oe_n       = s_r.mosi_oe_n;
   assign miso_out        = s_r.miso_o;
   assign miso_oe_n       = s_r.miso_oe_n;
   assign irq             = s_r.irq;
   assign asleep          = s_r.asleep;
   assign osc_run         = s_r.osc_run;
   assign gain_cut_20db   = s_r.gain_cut_20db;
   assign gain_cut_40db   = s_r.gain_cut_40db;
   assign agc_active      = s_r.agc_active;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || !ce);

   sequence force_write;
      spi_data && s_r.dir && s_r.addr == `ADR_XACT_CFG && ifc.rx_byte[`XACT_FORCE]
         && ifc.rx_byte[`XACT_END_HI:`XACT_END_LO] == `END_SLEEP;
   endsequence
   sequence read_cmd;
      ifc.rx_valid && ifc.rx_first && !ifc.rx_byte[`CMD_DIR];
   endsequence

   a_force_sleep_entry:
      assert property (force_write |-> ##[1:2] asleep && !osc_run)
      else $error("forced sleep not entered");
   a_read_cmd_decode:
      assert property (read_cmd |=> s_r.cmd_valid && !s_r.dir)
      else $error("read command not decoded");
   a_wake_done:
      assert property (s_r.pw == radio_spi_pkg::PW_WAKING && s_r.osc_cnt == '0
                       |=> s_r.pw == radio_spi_pkg::PW_AWAKE && s_r.wake_flag)
      else $error("wake completion wrong");
   a_lowbat_sleep_off:
      assert property (s_r.pw != radio_spi_pkg::PW_AWAKE
                       && !(s_r.ctrl[`CTRL_WAKE_IE] && s_r.wake_flag) |=> !irq)
      else $error("battery monitor active while not awake");
   a_shared_irq_quiet:
      assert property (shared && four && !ifc.ss_n_s && $past(!ifc.ss_n_s) |=> mosi_oe_n)
      else $error("master-out driven while selected");
   a_burst_advance:
      assert property (spi_data && s_r.inc |=> s_r.addr == $past(s_r.addr) + 6'h01)
      else $error("burst address not advanced");
   a_burst_hold:
      assert property (spi_data && !s_r.inc |=> s_r.addr == $past(s_r.addr))
      else $error("burst address moved");
   a_signal_strength_reading_spacing:
      assert property (s_r.signal_strength_reading_gap != '0 |=> s_r.signal_strength_reading == $past(s_r.signal_strength_reading))
      else $error("strength reading changed too soon");
   a_lowbat_unlatched:
      assert property (!lowbat_now && !s_r.wake_flag |=> !irq && mosi_out == $past(ifc.sdo)
                       || !mosi_oe_n && shared)
      else $error("battery interrupt latched");
endmodule
`default_nettype wire

// file: core/radio_spi_defines.svh
// register map, field positions and timing figures of the radio serial port
// assumes a 4 ns system clock; included by the package, whose macros the top module also uses
`ifndef RADIO_SPI_DEFINES_SVH
`define RADIO_SPI_DEFINES_SVH
`define CLK_PERIOD_NS   4
`define OSC_RESTART_NS  2000
`define SIGNAL_STRENGTH_READING_GAP_NS     12000
`define OSC_CNT_W       10
`define SIGNAL_STRENGTH_READING_CNT_W      12
`define BUF_DEPTH       16
`define ADR_CTRL        6'h02
`define ADR_STATUS      6'h04
`define ADR_RX_CFG      6'h06
`define ADR_XACT_CFG    6'h0F
`define ADR_SIGNAL_STRENGTH_READING        6'h13
`define ADR_LOWBAT      6'h1A
`define ADR_BUFFER      6'h20
`define ADR_SPI_CFG     6'h3D
`define AV_IDX_HI       7
`define AV_IDX_LO       2
`define CMD_DIR         7
`define CMD_INC         6
`define CMD_ADR_HI      5
`define CTRL_AUTO_SLEEP 0
`define CTRL_WAKE_IE    1
`define CTRL_TX_GO      2
`define CTRL_RX_GO      3
`define CTRL_GO_MASK    8'h0C
`define XACT_FORCE      5
`define XACT_END_HI     4
`define XACT_END_LO     2
`define END_SLEEP       3'h0
`define RXCFG_AGC       7
`define RXCFG_LNA       6
`define RXCFG_DAMP      5
`define RXCFG_SIGNAL_STRENGTH_READING_EN   1
`define LOWBAT_THR_HI   2
`define LOWBAT_IE       3
`define LOWBAT_LIVE     7
`define SPICFG_SWAP     7
`define SPICFG_FOUR     1
`define SPICFG_IRQ_MOSI 0
`define ST_ASLEEP       0
`define ST_WAKING       1
`define ST_WAKE         2
`define ST_LOWBAT       3
`define RST_RX_CFG      8'h40
`define SYNC_INIT       13'h0002
`endif

// file: core/radio_spi_pkg.sv
// types shared by the serial port modules
// assumes the defines header for field widths
`include "radio_spi_defines.svh"
package radio_spi_pkg;
   typedef enum logic [1:0] {
      PW_AWAKE  = 2'h0,
      PW_SLEEP  = 2'h1,
      PW_WAKING = 2'h2
   } pw_t;

   typedef struct packed {
      logic       sck_d;
      logic [2:0] bits;
      logic [7:0] sin;
      logic [7:0] sout;
      logic       first;
      logic       rx_valid;
      logic       rx_first;
      logic [7:0] rx_byte;
      logic       sdo;
   } eng_state_t;

   typedef struct packed {
      pw_t                             pw;
      logic [`OSC_CNT_W-1:0]           osc_cnt;
      logic                            wake_flag;
      logic                            cmd_valid;
      logic                            dir;
      logic                            inc;
      logic [5:0]                      addr;
      logic [7:0]                      tx_byte;
      logic [7:0]                      spi_cfg;
      logic [7:0]                      xact;
      logic [7:0]                      rx_cfg;
      logic [7:0]                      lowbat_cfg;
      logic [7:0]                      ctrl;
      logic [4:0]                      signal_strength_reading;
      logic                            signal_strength_reading_pend;
      logic [`SIGNAL_STRENGTH_READING_CNT_W-1:0]          signal_strength_reading_gap;
      logic [`BUF_DEPTH-1:0][7:0]      buf_mem;
      logic [3:0]                      bptr;
      logic                            pstart_d;
      logic                            pdone_d;
      logic                            av_wait;
      logic [7:0]                      av_rdata;
      logic                            irq;
      logic                            mosi_o;
      logic                            mosi_oe_n;
      logic                            miso_o;
      logic                            miso_oe_n;
      logic                            gain_cut_20db;
      logic                            gain_cut_40db;
      logic                            agc_active;
      logic                            asleep;
      logic                            osc_run;
   } port_state_t;
endpackage

// file: core/spi_shift_if.sv
// byte-level link between the shift engine and the register core
// all signals live in the system clock domain
`timescale 1ns/1ps
`default_nettype none
interface spi_shift_if;
   logic       sck_s;
   logic       ss_n_s;
   logic       sdi_s;
   logic       rx_valid;
   logic       rx_first;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic       sdo;
   modport engine (input sck_s, ss_n_s, sdi_s, tx_byte,
                   output rx_valid, rx_first, rx_byte, sdo);
   modport core (output sck_s, ss_n_s, sdi_s, tx_byte,
                 input rx_valid, rx_first, rx_byte, sdo);
endinterface
`default_nettype wire

// file: core/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes each bit is an independent level; reset value given per bit
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t s_r;
   sync_t s_nxt;

   always_comb
   begin
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         s_r <= {INIT, INIT};
      else if (ce)
         s_r <= s_nxt;
   end

   assign q = s_r.s2;
endmodule
`default_nettype wire

// file: core/spi_shift_engine.sv
// serial shifter: finds clock edges on synchronised pins, builds bytes
// assumes pins already pass two flops; clock idles low
`timescale 1ns/1ps
`default_nettype none
module spi_shift_engine (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   spi_shift_if.engine      ifc
);
   radio_spi_pkg::eng_state_t s_r;
   radio_spi_pkg::eng_state_t s_nxt;
   logic                      rise;
   logic                      fall;

   always_comb
   begin
      s_nxt = s_r;
      rise = ifc.sck_s && !s_r.sck_d;
      fall = !ifc.sck_s && s_r.sck_d;
      s_nxt.sck_d = ifc.sck_s;
      s_nxt.rx_valid = 1'b0;
      if (ifc.ss_n_s)
      begin
         s_nxt.bits = 3'h0;
         s_nxt.first = 1'b1;
      end
      else if (rise)
      begin
         s_nxt.sin = {s_r.sin[6:0], ifc.sdi_s};
         s_nxt.bits = s_r.bits + 3'h1;
         if (s_r.bits == 3'h7)
         begin
            s_nxt.rx_valid = 1'b1;
            s_nxt.rx_first = s_r.first;
            s_nxt.rx_byte = {s_r.sin[6:0], ifc.sdi_s};
            s_nxt.first = 1'b0;
         end
      end
      else if (fall)
      begin
         if (s_r.bits == 3'h0)
         begin
            s_nxt.sdo = ifc.tx_byte[7];
            s_nxt.sout = {ifc.tx_byte[6:0], 1'b0};
         end
         else
         begin
            s_nxt.sdo = s_r.sout[7];
            s_nxt.sout = {s_r.sout[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         s_r <= '0;
      else if (ce)
         s_r <= s_nxt;
   end

   assign ifc.rx_valid = s_r.rx_valid;
   assign ifc.rx_first = s_r.rx_first;
   assign ifc.rx_byte  = s_r.rx_byte;
   assign ifc.sdo      = s_r.sdo;
endmodule
`default_nettype wire

// file: tb/spi_master_model.sv
// serial master model on the port's pins
// assumes tasks are entered right after a clk edge
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   input  wire logic clk,
   input  wire logic mosi_oe_n,
   input  wire logic mosi_out,
   input  wire logic miso_out,
   input  wire logic miso_oe_n,
   output var  logic sck,
   output var  logic ss_n,
   output var  logic mosi_in
);
   logic drv_r, dat_r, last_r, four;
   initial
   begin
      {sck, ss_n, drv_r, dat_r, last_r, four} = 6'h10;
   end
   always_comb mosi_in = !mosi_oe_n ? mosi_out : drv_r ? dat_r : !last_r;
   always @(posedge clk) last_r <= mosi_in;
   task automatic sel(input logic v);
      sck <= 1'h0;
      drv_r <= 1'h0;
      repeat (10) @(posedge clk);
      ss_n <= v;
      repeat (10) @(posedge clk);
   endtask
   task automatic xb(input logic [7:0] tx, input logic d, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         sck <= 1'h0;
         dat_r <= tx[i];
         drv_r <= d;
         repeat (10) @(posedge clk);
         sck <= 1'h1;
         rx[i] = four ? (miso_oe_n ? !miso_out : miso_out) : mosi_in;
         repeat (10) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// file: tb/radio_spi_slave_port_tb.sv
// bench for the radio serial slave port
// assumes the serial master model on the pins
`timescale 1ns/1ps
`default_nettype none
module radio_spi_slave_port_tb;
   logic        clk, resetn, avs_read, avs_write, avs_waitrequest, sck, ss_n, mosi_in;
   logic        mosi_out, mosi_oe_n, miso_out, irq, asleep, osc_run;
   logic        gain_cut_20db, gain_cut_40db, agc_active, miso_oe_n, pkt_start, pkt_done;
   logic [4:0]  rf_level;
   logic [7:0]  avs_address, rx;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [2:0]  battery_level;
   int          error_cnt, checks_done, cyc;
   radio_spi_slave_port #(.OSC_NS(40), .SIGNAL_STRENGTH_READING_NS(80)) radio_spi_slave_port_i (
      .clk, .resetn, .ce(1'h1), .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .sck, .ss_n, .mosi_in, .mosi_out, .mosi_oe_n,
      .miso_out, .miso_oe_n, .irq, .battery_level, .rf_level,
      .pkt_start, .pkt_done, .asleep, .osc_run, .gain_cut_20db,
      .gain_cut_40db, .agc_active);
   spi_master_model spi_master_model_i (
      .clk, .mosi_oe_n, .mosi_out, .miso_out, .miso_oe_n, .sck, .ss_n, .mosi_in);
   initial
   begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic av(input logic w, input logic [7:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h000000, d};
      do @(posedge clk); while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      repeat (2) @(posedge clk);
   endtask
   task automatic sx(input logic [7:0] c, input logic [7:0] d, input logic w);
      spi_master_model_i.sel(1'h0);
      spi_master_model_i.xb(c, 1'h1, rx);
      spi_master_model_i.xb(d, w, rx);
      spi_master_model_i.sel(1'h1);
   endtask
   task automatic t_regs();
      av(1'h0, 8'h18, 8'h00);
      chk("rx_cfg", 32'h40, rd);
      av(1'h0, 8'h04, 8'h00);
      chk("unmapped", 32'h0, rd);
      av(1'h1, 8'h18, 8'h20);
      chk("gain cut", 32'h3, {gain_cut_40db, gain_cut_20db});
      av(1'h1, 8'h18, 8'hA0);
      chk("agc", 32'h4, {agc_active, gain_cut_40db, gain_cut_20db});
   endtask
   task automatic t_spi();
      sx(8'h86, 8'h42, 1'h1);
      av(1'h0, 8'h18, 8'h00);
      chk("spi write", 32'h42, rd);
      chk("gain full", 32'h0, {gain_cut_40db, gain_cut_20db});
      sx(8'h06, 8'h00, 1'h0);
      chk("3w read", 32'h42, rx);
      av(1'h1, 8'hF4, 8'h02);
      spi_master_model_i.four = 1'h1;
      sx(8'h06, 8'h00, 1'h0);
      chk("4w read", 32'h42, rx);
      spi_master_model_i.four = 1'h0;
      av(1'h1, 8'hF4, 8'h00);
   endtask
   task automatic t_sleep();
      sx(8'h8F, 8'h20, 1'h1);
      chk("sleep", 32'h2, {asleep, osc_run});
      sx(8'h06, 8'h00, 1'h0);
      chk("sleep read", 32'h42, rx);
      av(1'h1, 8'h08, 8'h06);
      chk("early irq", 32'h0, irq);
      repeat (20) @(posedge clk);
      chk("woken", 32'h3, {asleep, osc_run, irq});
      av(1'h0, 8'h10, 8'h00);
      chk("status", 32'h4, rd);
      chk("irq clear", 32'h0, irq);
   endtask
   task automatic bx(input logic [7:0] c, input logic [15:0] d);
      spi_master_model_i.sel(1'h0);
      spi_master_model_i.xb(c, 1'h1, rx);
      spi_master_model_i.xb(d[15:8], 1'h1, rx);
      spi_master_model_i.xb(d[7:0], 1'h1, rx);
      spi_master_model_i.sel(1'h1);
   endtask
   task automatic t_burst();
      bx(8'hD9, 16'h0005);
      av(1'h0, 8'h68, 8'h00);
      chk("inc burst", 32'h05, rd);
      bx(8'h9A, 16'h0102);
      av(1'h0, 8'h68, 8'h00);
      chk("hold burst", 32'h02, rd);
   endtask
   task automatic t_pkt();
      rf_level <= 5'h15;
      pkt_start <= 1'h1;
      repeat (8) @(posedge clk);
      rf_level <= 5'h0A;
      pkt_start <= 1'h0;
      av(1'h0, 8'h4C, 8'h00);
      chk("signal_strength_reading start", 32'h15, rd);
      av(1'h0, 8'h4C, 8'h00);
      chk("signal_strength_reading gap", 32'h15, rd);
      repeat (20) @(posedge clk);
      av(1'h0, 8'h4C, 8'h00);
      chk("signal_strength_reading fresh", 32'h0A, rd);
      av(1'h1, 8'h08, 8'h01);
      pkt_done <= 1'h1;
      repeat (8) @(posedge clk);
      chk("auto sleep", 32'h1, asleep);
      pkt_done <= 1'h0;
      av(1'h1, 8'h08, 8'h04);
      repeat (20) @(posedge clk);
      chk("tx wake", 32'h1, osc_run);
   endtask
   task automatic t_bat();
      av(1'h1, 8'h68, 8'h0B);
      battery_level <= 3'h1;
      repeat (8) @(posedge clk);
      chk("low irq", 32'h1, irq);
      av(1'h1, 8'hF4, 8'h03);
      chk("shared irq", 32'h2, {mosi_oe_n, mosi_out, irq});
      spi_master_model_i.sel(1'h0);
      chk("shared quiet", 32'h1, mosi_oe_n);
      spi_master_model_i.sel(1'h1);
      av(1'h1, 8'hF4, 8'h00);
      av(1'h0, 8'h68, 8'h00);
      chk("live", 32'h8B, rd);
      battery_level <= 3'h5;
      repeat (8) @(posedge clk);
      chk("recover", 32'h0, irq);
      sx(8'h8F, 8'h20, 1'h1);
      battery_level <= 3'h1;
      repeat (8) @(posedge clk);
      chk("sleep bat", 32'h0, irq);
   endtask
   task automatic final_report();
      if (error_cnt == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         error_cnt++;
         final_report();
      end
   end
   initial
   begin
      {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
      battery_level = 3'h7;
      {rf_level, pkt_start, pkt_done} = '0;
      repeat (10) @(posedge clk);
      resetn <= 1'h1;
      t_regs();
      t_spi();
      t_burst();
      t_sleep();
      t_pkt();
      t_bat();
      final_report();
   end
endmodule
`default_nettype wire
